// File: fsq_pkg.sv
package fsq_pkg;
  // link request kinds
  typedef enum logic [2:0] {
    FSQ_TRD_LOW  = 3'h0,  // table_read_low
    FSQ_TRD_HIGH = 3'h1,  // table_read_high
    FSQ_TWR_LOW  = 3'h2,  // table_write_low
    FSQ_TWR_HIGH = 3'h3,  // table_write_high
    FSQ_SFR_WR   = 3'h4,  // register write, index in ea[1:0]
    FSQ_SFR_RD   = 3'h5   // register read, index in ea[1:0]
  } fsq_op_type;
  // device register indices
  localparam logic [1:0]  FSQ_SFR_CONTROL  = 2'h0;  // nvm_control
  localparam logic [1:0]  FSQ_SFR_ADDR_LO  = 2'h1;  // nvm_address_low
  localparam logic [1:0]  FSQ_SFR_ADDR_UP  = 2'h2;  // nvm_address_upper
  localparam logic [1:0]  FSQ_SFR_KEY      = 2'h3;  // nvm_unlock_key
  // nvm_control fields
  localparam int          FSQ_CTL_START    = 15;
  localparam int          FSQ_CTL_WRITE_ENABLE_BIT     = 14;
  localparam int          FSQ_CTL_ERR      = 13;
  localparam logic [15:0] FSQ_CTL_RESET    = 16'h0000;
  localparam logic [6:0]  FSQ_OPSEL_ERASE  = 7'h41;  // erase one row
  localparam logic [6:0]  FSQ_OPSEL_PROG   = 7'h01;  // program one row
  // unlock keys
  localparam logic [7:0]  FSQ_KEY_FIRST    = 8'h55;
  localparam logic [7:0]  FSQ_KEY_SECOND   = 8'hAA;
  // flash geometry
  localparam int          FSQ_ROW_WORDS    = 32;
  localparam int          FSQ_PANEL_ROWS   = 128;
  localparam logic [23:0] FSQ_ERASED_WORD  = 24'hFFFFFF;
  // timing
  localparam int          FSQ_CLK_MHZ      = 25;
  localparam int          FSQ_CYCLE_US     = 2000;
  localparam int          FSQ_CYCLE_CLKS   = FSQ_CYCLE_US * FSQ_CLK_MHZ;
  localparam int          FSQ_TABLE_WRITE_OP_CLKS   = 2;
  // request word: op, byte, page, ea, wdata
  localparam int          FSQ_REQ_W        = 44;
  // host apb register offsets
  localparam logic [11:0] FSQ_HOST_CMD     = 12'h000;
  localparam logic [11:0] FSQ_HOST_ADDR    = 12'h004;
  localparam logic [11:0] FSQ_HOST_WDATA   = 12'h008;
  localparam logic [11:0] FSQ_HOST_STATUS  = 12'h00C;
  localparam logic [11:0] FSQ_HOST_RDATA   = 12'h010;
endpackage

// File: fsq_link_if.sv
`timescale 1ns/1ns
interface fsq_link_if;
  logic        req_valid;  // host offers a request
  logic        req_ready;  // device buffer has room
  logic [2:0]  req_op;     // fsq_op_type code
  logic        req_byte;   // byte mode
  logic [7:0]  req_page;   // table_page_register bits 7:0
  logic [15:0] req_ea;     // effective_address
  logic [15:0] req_wdata;  // write data
  logic        rsp_valid;  // one-cycle answer pulse
  logic [15:0] rsp_rdata;  // read data with the answer
  logic        stall;      // processor held during a flash cycle
  modport dev (input req_valid, req_op, req_byte, req_page, req_ea, req_wdata,
               output req_ready, rsp_valid, rsp_rdata, stall);
  modport host (output req_valid, req_op, req_byte, req_page, req_ea, req_wdata,
                input req_ready, rsp_valid, rsp_rdata, stall);
endinterface

// File: fsq_buf2.sv
`timescale 1ns/1ns
// two-entry fifo; ready and valid come from flops
module fsq_buf2 #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  logic [WIDTH-1:0] mem_q [2];  // entry storage
  logic             rd_q;       // read slot
  logic             wr_q;       // write slot
  logic [1:0]       cnt_q;      // entries held
  logic [1:0]       cnt_d;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  // count follows push and pop
  always_comb begin
    cnt_d = cnt_q;
    if (push & ~pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop & ~push) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  // pointers and flags; flags registered so a stall shows one edge later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_q      <= 1'b0;
      wr_q      <= 1'b0;
      cnt_q     <= 2'h0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      rd_q      <= rd_q ^ pop;
      wr_q      <= wr_q ^ push;
      cnt_q     <= cnt_d;
      in_ready  <= (cnt_d != 2'h2);
      out_valid <= (cnt_d != 2'h0);
    end
  end

  // storage needs no reset
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  assign out_data = mem_q[rd_q];
endmodule // fsq_buf2

// File: fsq_dev_end.sv
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ns
// Function
// - low table ops reach bits 15:0, word/byte
// - high table ops reach bits 23:16, word/byte
// - address is page 7:0 joined with ea
// - rows of 32 words; erase clears one row
// - panels of 128 rows; requester repoints at boundary
// - per-panel latches hold 32 pending words
// - requester loads latches ascending from row start
// - table write takes 2 cycles, latches only
// - one program cycle per row moves latches
// - low capture holds ea 15:0 of table op
// - upper capture holds address bits 23:16
// - key register write-only; 0x55 then 0xAA unlock
// - capture registers also writable by software
// - cycle lasts 2 ms; processor stalled throughout
// - start bit 15 launches; hardware clears it
// - control selects erase or program operation
// - requester sets op and write enable first
module fsq_dev_end #(
  parameter int FLASH_ROWS = 256,
  parameter int CYCLE_CLKS = fsq_pkg::FSQ_CYCLE_CLKS
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // link toward the processor core
  fsq_link_if.dev   link,
  // user-side status
  output logic      cycle_busy,
  output logic      cycle_error
);
  localparam int WORDS   = FLASH_ROWS * fsq_pkg::FSQ_ROW_WORDS;
  localparam int PANELS  = (FLASH_ROWS + fsq_pkg::FSQ_PANEL_ROWS - 1) / fsq_pkg::FSQ_PANEL_ROWS;
  localparam int LATCHES = PANELS * fsq_pkg::FSQ_ROW_WORDS;
  localparam int IW      = $clog2(WORDS);
  localparam int LW      = $clog2(LATCHES);
  localparam int CW      = $clog2(CYCLE_CLKS + 1);

  typedef enum logic [1:0] {
    FSQ_S_IDLE = 2'b00,  // waiting for a request
    FSQ_S_EXEC = 2'b01,  // executing a request
    FSQ_S_BUSY = 2'b11   // flash cycle running
  } fsq_dev_state_type;

  fsq_dev_state_type state_q;        // sequencer state
  logic [23:0]       flash_q [WORDS];   // program array
  logic [23:0]       latch_q [LATCHES]; // write latches, one row per panel
  logic              q_valid;        // buffered request present
  logic [43:0]       q_data;         // buffered request
  logic [2:0]        op_q;           // current request fields
  logic              byte_q;
  logic [7:0]        page_q;
  logic [15:0]       ea_q;
  logic [15:0]       wdata_q;
  logic              step_q;         // table write second cycle
  logic [CW-1:0]     cnt_q;          // flash cycle timer
  logic              start_q;        // control start bit
  logic              write_enable_bit_q;         // write_enable_bit
  logic              err_q;          // error flag
  logic [6:0]        opsel_q;        // operation select
  logic [15:0]       adr_lo_q;       // nvm_address_low
  logic [7:0]        adr_up_q;       // nvm_address_upper
  logic              key1_q;         // first key seen
  logic              unlock_q;       // both keys seen
  logic              rsp_valid_q;
  logic [15:0]       rsp_rdata_q;
  logic              pop;            // buffered request taken this edge

  // request buffer keeps words while a flash cycle stalls the core
  fsq_buf2 #(.WIDTH(fsq_pkg::FSQ_REQ_W)) fsq_buf2_i (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (link.req_valid),
    .in_ready  (link.req_ready),
    .in_data   ({link.req_op, link.req_byte, link.req_page, link.req_ea, link.req_wdata}),
    .out_valid (q_valid),
    .out_ready (pop),
    .out_data  (q_data)
  );

  // decode of the current request
  assign pop = (state_q == FSQ_S_IDLE) & q_valid;
  wire [23:0] addr     = {page_q, ea_q};
  wire        is_tw    = (op_q == fsq_pkg::FSQ_TWR_LOW) | (op_q == fsq_pkg::FSQ_TWR_HIGH);
  wire        is_tab   = ~op_q[2];
  wire        is_sfr_w = (op_q == fsq_pkg::FSQ_SFR_WR);
  wire [1:0]  sel      = ea_q[1:0];
  wire        last     = ~is_tw | step_q;
  wire        ex_end   = (state_q == FSQ_S_EXEC) & last;
  wire        word_ok  = ({9'h000, addr[23:1]} < WORDS);
  wire [IW-1:0] widx   = addr[IW:1];
  wire [23:0] rd_word  = word_ok ? flash_q[widx] : 24'h000000;
  wire [15:0] rd_low   = byte_q ? {8'h00, (addr[0] ? rd_word[15:8] : rd_word[7:0])} : rd_word[15:0];
  wire [15:0] rd_high  = (byte_q & addr[0]) ? 16'h0000 : {8'h00, rd_word[23:16]};
  // latch slot: panel of the address, slot within its row
  wire        lat_ok   = ({21'h000000, addr[23:13]} < LATCHES / fsq_pkg::FSQ_ROW_WORDS);
  wire [15:0] lat_full = {addr[23:13], addr[5:1]};
  wire [LW-1:0] lidx   = lat_full[LW-1:0];
  wire [23:0] lat_old  = latch_q[lidx];
  wire        lo_hi_b  = byte_q & addr[0];
  wire [23:0] lat_new  = (op_q == fsq_pkg::FSQ_TWR_LOW) ?
                         (byte_q ? (lo_hi_b ? {lat_old[23:16], wdata_q[7:0], lat_old[7:0]}
                                            : {lat_old[23:8], wdata_q[7:0]})
                                 : {lat_old[23:16], wdata_q}) :
                         (lo_hi_b ? lat_old : {wdata_q[7:0], lat_old[15:0]});
  // control register image and read mux
  wire [15:0] ctl_rd   = {start_q, write_enable_bit_q, err_q, 6'h00, opsel_q};
  wire [15:0] sfr_rd   = (sel == fsq_pkg::FSQ_SFR_CONTROL) ? ctl_rd :
                         (sel == fsq_pkg::FSQ_SFR_ADDR_LO) ? adr_lo_q :
                         (sel == fsq_pkg::FSQ_SFR_ADDR_UP) ? {8'h00, adr_up_q} : 16'h0000;
  // launch check on a control write
  wire [23:0] nvm_addr = {adr_up_q, adr_lo_q};
  wire        row_ok   = ({6'h00, nvm_addr[23:6]} < FLASH_ROWS);
  wire        ctl_wr   = ex_end & is_sfr_w & (sel == fsq_pkg::FSQ_SFR_CONTROL);
  wire        key_wr   = ex_end & is_sfr_w & (sel == fsq_pkg::FSQ_SFR_KEY);
  wire        want     = ctl_wr & wdata_q[fsq_pkg::FSQ_CTL_START] & wdata_q[fsq_pkg::FSQ_CTL_WRITE_ENABLE_BIT] & unlock_q;
  wire        op_ok    = (wdata_q[6:0] == fsq_pkg::FSQ_OPSEL_ERASE) | (wdata_q[6:0] == fsq_pkg::FSQ_OPSEL_PROG);
  wire        launch   = want & op_ok & row_ok;
  wire        bad_go   = want & ~launch;
  wire        cyc_end  = (state_q == FSQ_S_BUSY) & (cnt_q == CW'(CYCLE_CLKS - 1));
  wire [IW-1:0] row_base = {nvm_addr[IW:6], 5'h00};
  wire [15:0] pan_full = {nvm_addr[23:13], 5'h00};
  wire [LW-1:0] pan_base = pan_full[LW-1:0];

  // sequencer: take a request, run it, answer; a launch answers at cycle end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= FSQ_S_IDLE;
      step_q  <= 1'b0;
      cnt_q   <= '0;
    end else begin
      case (state_q)
        FSQ_S_IDLE: begin
          step_q <= 1'b0;
          if (q_valid) begin
            state_q <= FSQ_S_EXEC;
          end
        end
        FSQ_S_EXEC: begin
          step_q <= ~last;
          cnt_q  <= '0;
          if (last) begin
            state_q <= launch ? FSQ_S_BUSY : FSQ_S_IDLE;
          end
        end
        FSQ_S_BUSY: begin
          cnt_q <= cnt_q + CW'(1);
          if (cyc_end) begin
            state_q <= FSQ_S_IDLE;
          end
        end
        default: begin
          state_q <= FSQ_S_IDLE;
        end
      endcase
    end
  end

  // request capture
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {op_q, byte_q, page_q, ea_q, wdata_q} <= '0;
    end else if (pop) begin
      {op_q, byte_q, page_q, ea_q, wdata_q} <= q_data;
    end
  end

  // control register; start set only by a valid launch, cleared at cycle end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {start_q, write_enable_bit_q, err_q} <= 3'h0;
      opsel_q <= fsq_pkg::FSQ_CTL_RESET[6:0];
    end else if (cyc_end) begin
      start_q <= 1'b0;
    end else if (ctl_wr) begin
      start_q <= launch;
      write_enable_bit_q  <= wdata_q[fsq_pkg::FSQ_CTL_WRITE_ENABLE_BIT];
      err_q   <= wdata_q[fsq_pkg::FSQ_CTL_ERR] | bad_go;
      opsel_q <= wdata_q[6:0];
    end
  end

  // address capture: table ops and direct writes both load it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      adr_lo_q <= 16'h0000;
      adr_up_q <= 8'h00;
    end else if (ex_end & is_tab) begin
      adr_lo_q <= ea_q;
      adr_up_q <= page_q;
    end else if (ex_end & is_sfr_w & (sel == fsq_pkg::FSQ_SFR_ADDR_LO)) begin
      adr_lo_q <= wdata_q;
    end else if (ex_end & is_sfr_w & (sel == fsq_pkg::FSQ_SFR_ADDR_UP)) begin
      adr_up_q <= wdata_q[7:0];
    end
  end

  // unlock: 0x55 then 0xAA back to back; any other key write or a control write drops it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      key1_q   <= 1'b0;
      unlock_q <= 1'b0;
    end else if (key_wr) begin
      key1_q   <= (wdata_q[7:0] == fsq_pkg::FSQ_KEY_FIRST);
      unlock_q <= key1_q & (wdata_q[7:0] == fsq_pkg::FSQ_KEY_SECOND);
    end else if (ctl_wr) begin
      key1_q   <= 1'b0;
      unlock_q <= 1'b0;
    end
  end

  // answers: pulse at request end, or at cycle end for a launch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= 16'h0000;
    end else begin
      rsp_valid_q <= (ex_end & ~launch) | cyc_end;
      if (ex_end) begin
        rsp_rdata_q <= (op_q == fsq_pkg::FSQ_TRD_LOW)  ? rd_low :
                       (op_q == fsq_pkg::FSQ_TRD_HIGH) ? rd_high :
                       (op_q == fsq_pkg::FSQ_SFR_RD)   ? sfr_rd : 16'h0000;
      end
    end
  end

  // array and latches; flash is nonvolatile so it takes no reset
  always_ff @(posedge clk) begin
    if (ex_end & is_tw & lat_ok) begin
      latch_q[lidx] <= lat_new;
    end
    if (cyc_end) begin
      for (int i = 0; i < fsq_pkg::FSQ_ROW_WORDS; i++) begin
        flash_q[row_base + IW'(i)] <= (opsel_q == fsq_pkg::FSQ_OPSEL_PROG) ?
                                      latch_q[pan_base + LW'(i)] : fsq_pkg::FSQ_ERASED_WORD;
      end
    end
  end

  // status flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cycle_busy  <= 1'b0;
      cycle_error <= 1'b0;
    end else begin
      cycle_busy  <= launch | ((state_q == FSQ_S_BUSY) & ~cyc_end);
      cycle_error <= ctl_wr ? (wdata_q[fsq_pkg::FSQ_CTL_ERR] | bad_go) : err_q;
    end
  end

  assign link.rsp_valid = rsp_valid_q;
  assign link.rsp_rdata = rsp_rdata_q;
  assign link.stall     = cycle_busy;
endmodule // fsq_dev_end

// File: fsq_host_end.sv
`timescale 1ns/1ns
// processor-side end: software orders table and register accesses over apb
module fsq_host_end (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // link toward the device
  fsq_link_if.host         link
);
  logic        req_valid_q;  // request on the link
  logic [2:0]  op_q;         // request kind
  logic        byte_q;       // byte mode
  logic [7:0]  page_q;       // table_page_register
  logic [15:0] ea_q;         // effective_address
  logic [15:0] wdata_q;      // write data
  logic        pend_q;       // waiting for an answer
  logic [15:0] rdata_q;      // last answer data

  // apb decode; pready comes one edge into the access phase
  wire        acc      = psel & penable;
  wire        fire     = acc & pready;
  wire        hit_cmd  = (paddr == fsq_pkg::FSQ_HOST_CMD);
  wire        hit_addr = (paddr == fsq_pkg::FSQ_HOST_ADDR);
  wire        hit_wd   = (paddr == fsq_pkg::FSQ_HOST_WDATA);
  wire        hit_st   = (paddr == fsq_pkg::FSQ_HOST_STATUS);
  wire        hit_rd   = (paddr == fsq_pkg::FSQ_HOST_RDATA);
  wire        mapped   = hit_cmd | hit_addr | hit_wd | hit_st | hit_rd;
  // a command while one is outstanding is refused
  wire        cmd_bad  = pwrite & hit_cmd & pend_q;
  wire        err      = ~mapped | cmd_bad;
  wire        go       = fire & pwrite & hit_cmd & ~pend_q;
  wire [31:0] rd_mux   = hit_cmd  ? {28'h0000000, byte_q, op_q} :
                         hit_addr ? {8'h00, page_q, ea_q} :
                         hit_wd   ? {16'h0000, wdata_q} :
                         hit_st   ? {30'h00000000, link.stall, pend_q} :
                         hit_rd   ? {16'h0000, rdata_q} : 32'h00000000;

  // apb answer flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= acc & ~pready;
      pslverr <= acc & ~pready & err;
      prdata  <= (acc & ~pready & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // software registers; the page travels with every request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {op_q, byte_q} <= 4'h0;
      {page_q, ea_q} <= 24'h000000;
      wdata_q        <= 16'h0000;
    end else if (fire & pwrite & ~err) begin
      if (hit_cmd) begin
        {byte_q, op_q} <= pwdata[3:0];
      end
      if (hit_addr) begin
        {page_q, ea_q} <= pwdata[23:0];
      end
      if (hit_wd) begin
        wdata_q <= pwdata[15:0];
      end
    end
  end

  // one request at a time: offer until taken, then wait for the answer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_valid_q <= 1'b0;
      pend_q      <= 1'b0;
      rdata_q     <= 16'h0000;
    end else begin
      if (go) begin
        req_valid_q <= 1'b1;
        pend_q      <= 1'b1;
      end else begin
        if (req_valid_q & link.req_ready) begin
          req_valid_q <= 1'b0;
        end
        if (link.rsp_valid) begin
          pend_q  <= 1'b0;
          rdata_q <= link.rsp_rdata;
        end
      end
    end
  end

  assign link.req_valid = req_valid_q;
  assign link.req_op    = op_q;
  assign link.req_byte  = byte_q;
  assign link.req_page  = page_q;
  assign link.req_ea    = ea_q;
  assign link.req_wdata = wdata_q;
endmodule // fsq_host_end

// File: fsq_link_props.sv
`timescale 1ns/1ns
// watches the link: answer timing, read widths, flash cycle length
module fsq_link_props #(
  parameter int CYCLE_CLKS = 20
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // link signals
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic [2:0]  req_op,
  input wire logic        req_byte,
  input wire logic [15:0] req_ea,
  input wire logic        rsp_valid,
  input wire logic [15:0] rsp_rdata,
  input wire logic        stall
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire         take  = req_valid && req_ready;                  // request accepted
  wire         rd_tk = take && (req_op inside {3'h0, 3'h1, 3'h5}); // read accepted
  wire         wr_tk = take && (req_op[2:1] == 2'b01);          // table write accepted
  logic [31:0] run_q;                                           // stall cycles so far
  // length is judged when stall drops, so a stuck counter that never drops stall is not caught here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_q <= 32'h0;
    end else begin
      run_q <= stall ? run_q + 32'h1 : 32'h0;
    end
  end
  chk_read_lat: assert property (rd_tk |=> !rsp_valid ##1 !rsp_valid ##1 rsp_valid)
    else $error("read answer off time");
  chk_high_width: assert property (rd_tk && req_op == 3'h1 && !req_byte |-> ##3 rsp_rdata[15:8] == 8'h0)
    else $error("high read wider than a byte");
  chk_high_odd: assert property (rd_tk && req_op == 3'h1 && req_byte && req_ea[0] |-> ##3 rsp_rdata == 16'h0)
    else $error("odd high byte not zero");
  chk_twr_lat: assert property (wr_tk |=> !rsp_valid [*3] ##1 rsp_valid)
    else $error("table write answer off time");
  chk_twr_no_stall: assert property (wr_tk |=> !stall [*4])
    else $error("table write stalled");
  chk_key_zero: assert property (rd_tk && req_op == 3'h5 && req_ea[1:0] == 2'h3 |-> ##3 rsp_rdata == 16'h0)
    else $error("unlock key readable");
  chk_stall_len: assert property ($fell(stall) |-> run_q + 1 >= CYCLE_CLKS && run_q <= CYCLE_CLKS + 3)
    else $error("flash cycle length wrong");
  chk_stall_holds: assert property ($rose(stall) |-> !rsp_valid [*8])
    else $error("answer during flash cycle");
  cover property ($fell(stall));
  cover property (wr_tk);
  cover property (rd_tk && req_byte);
endmodule // fsq_link_props

// File: fsq_tb_top.sv
`timescale 1ns/1ns
// drives the host end over apb; a word-level flash model predicts the answers
module fsq_tb_top;
  localparam int CYC = 20;     // short flash cycle keeps the run brief
  // clock, reset, apb
  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  // device status
  logic        cycle_busy;
  logic        cycle_error;
  // scoreboard
  int          n_fail;
  int          comparisons;
  int          busy_n;         // busy cycles since the last launch
  logic [23:0] flash_m [int];  // model array by word index
  logic [23:0] latch_m [int];  // model latches by panel and slot
  fsq_link_if link_i ();
  fsq_host_end fsq_host_end_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link_i.host));
  fsq_dev_end #(.CYCLE_CLKS(CYC)) fsq_dev_end_i (.clk(clk), .rst(rst), .link(link_i.dev),
    .cycle_busy(cycle_busy), .cycle_error(cycle_error));
  fsq_link_props #(.CYCLE_CLKS(CYC)) fsq_link_props_i (.clk(clk), .rst(rst), .req_valid(link_i.req_valid),
    .req_ready(link_i.req_ready), .req_op(link_i.req_op), .req_byte(link_i.req_byte), .req_ea(link_i.req_ea),
    .rsp_valid(link_i.rsp_valid), .rsp_rdata(link_i.rsp_rdata), .stall(link_i.stall));
  always #20 clk = ~clk;
  // counts how long the processor is held
  always @(posedge clk) if (cycle_busy === 1'b1) busy_n <= busy_n + 1;
  task automatic give_verdict;
    if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // four-state compare so an unknown never matches
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  // a bounded wait that ran out ends the run
  task automatic bound(input logic ok);
    if (ok !== 1'b1) begin
      n_fail++;
      give_verdict();
    end
  endtask
  // one apb transfer; waits an edge first so no signal is assigned twice at once
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    bound(pready);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one link request through the host registers, polled to completion
  task automatic op(input logic [2:0] code, input logic byt, input logic [23:0] adr,
                    input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] q;
    logic        e;
    int          k;
    apb(1'b1, fsq_pkg::FSQ_HOST_ADDR, {8'h0, adr}, q, e);
    apb(1'b1, fsq_pkg::FSQ_HOST_WDATA, {16'h0, wd}, q, e);
    apb(1'b1, fsq_pkg::FSQ_HOST_CMD, {28'h0, byt, code}, q, e);
    k = 0;
    do begin
      apb(1'b0, fsq_pkg::FSQ_HOST_STATUS, 32'h0, q, e);
      k++;
    end while (q[0] !== 1'b0 && k < 100);
    bound(~q[0]);
    apb(1'b0, fsq_pkg::FSQ_HOST_RDATA, 32'h0, q, e);
    rd = q[15:0];
  endtask
  // device register write and checked read by index
  task automatic reg_wr(input logic [1:0] idx, input logic [15:0] v);
    logic [15:0] r;
    op(3'h4, 1'b0, {22'h0, idx}, v, r);
  endtask
  task automatic reg_chk(input string what, input logic [1:0] idx, input logic [15:0] exp);
    logic [15:0] r;
    op(3'h5, 1'b0, {22'h0, idx}, 16'h0, r);
    check(what, {16'h0, exp}, {16'h0, r});
  endtask
  // control first, since a control write drops the unlock; stray breaks the key pair
  task automatic launch(input logic [6:0] sel, input int row, input logic stray);
    reg_wr(2'h1, 16'(row * 64));
    reg_wr(2'h2, 16'h0);
    reg_wr(2'h0, {9'h080, sel});
    reg_wr(2'h3, 16'h0055);
    if (stray) reg_wr(2'h3, 16'h0);
    reg_wr(2'h3, 16'h00AA);
    busy_n = 0;
    reg_wr(2'h0, {9'h180, sel});
  endtask
  initial begin
    logic [15:0] r;
    logic [31:0] q;
    logic        e;
    logic [23:0] v;
    int          w;
    clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    n_fail = 0;
    comparisons = 0;
    busy_n = 0;
    w = $urandom(32'hFDB023DC);
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // unmapped host address is refused
    apb(1'b0, 12'h040, 32'h0, q, e);
    check("unmapped err", 32'h1, {31'h0, e});
    // direct capture writes, key reads as zero
    v = 24'($urandom);
    reg_wr(2'h1, v[15:0]);
    reg_chk("addr low", 2'h1, v[15:0]);
    reg_wr(2'h2, {8'h0, v[23:16]});
    reg_chk("addr up", 2'h2, {8'h0, v[23:16]});
    reg_chk("key", 2'h3, 16'h0);
    // latches of the last row of panel 0 and the first of panel 1, ascending
    for (int row = 127; row < 129; row++) begin
      for (int s = 0; s < 32; s++) begin
        v = 24'($urandom);
        op(3'h2, 1'b0, 24'(row * 64 + s * 2), v[15:0], r);
        op(3'h3, 1'b0, 24'(row * 64 + s * 2), {8'h0, v[23:16]}, r);
        latch_m[(row / 128) * 32 + s] = v;
      end
      reg_chk("capture low", 2'h1, 16'(row * 64 + 62));
      reg_chk("capture up", 2'h2, 16'h0);
    end
    // a nonzero page travels into the upper capture
    op(3'h0, 1'b0, {v[23:16] | 8'h01, 16'h0040}, 16'h0, r);
    reg_chk("capture page", 2'h2, {8'h0, v[23:16] | 8'h01});
    // erase then program each row; row 127 must survive the later erase of 128
    for (int row = 127; row < 129; row++) begin
      launch(fsq_pkg::FSQ_OPSEL_ERASE, row, 1'b0);
      for (int s = 0; s < 32; s++) flash_m[row * 32 + s] = 24'hFFFFFF;
      check("erase busy", 32'h1, {31'h0, busy_n >= CYC});
      op(3'h0, 1'b0, 24'(row * 64 + 10), 16'h0, r);
      check("erased word", {16'h0, flash_m[row * 32 + 5][15:0]}, {16'h0, r});
      reg_chk("ctl done", 2'h0, {9'h080, fsq_pkg::FSQ_OPSEL_ERASE});
      launch(fsq_pkg::FSQ_OPSEL_PROG, row, 1'b0);
      for (int s = 0; s < 32; s++) flash_m[row * 32 + s] = latch_m[(row / 128) * 32 + s];
    end
    // a stray key write between the pair blocks the start
    launch(fsq_pkg::FSQ_OPSEL_ERASE, 127, 1'b1);
    check("stray busy", 32'h0, 32'(busy_n));
    reg_chk("stray ctl", 2'h0, {9'h080, fsq_pkg::FSQ_OPSEL_ERASE});
    // an unknown operation select is refused and flags the error bit
    launch(7'h02, 127, 1'b0);
    check("bad op busy", 32'h0, 32'(busy_n));
    check("bad op err", 32'h1, {31'h0, cycle_error});
    reg_chk("bad op ctl", 2'h0, 16'h6002);
    reg_wr(2'h0, 16'h0000);
    // byte reads at an odd address
    v = flash_m[127 * 32 + 3];
    op(3'h0, 1'b1, 24'(127 * 64 + 7), 16'h0, r);
    check("odd low byte", {24'h0, v[15:8]}, {16'h0, r});
    op(3'h1, 1'b1, 24'(127 * 64 + 7), 16'h0, r);
    check("odd high byte", 32'h0, {16'h0, r});
    // both rows read back against the model
    for (int row = 127; row < 129; row++) begin
      for (int s = 0; s < 32; s++) begin
        v = flash_m[row * 32 + s];
        op(3'h0, 1'b0, 24'(row * 64 + s * 2), 16'h0, r);
        check("low word", {16'h0, v[15:0]}, {16'h0, r});
        op(3'h1, 1'b0, 24'(row * 64 + s * 2), 16'h0, r);
        check("high byte", {24'h0, v[23:16]}, {16'h0, r});
      end
    end
    check("error bit", 32'h0, {31'h0, cycle_error});
    give_verdict();
  end
endmodule // fsq_tb_top
